// [ppp_host_model.sv]
// Parallel bus controller model: strobes words into the port.
// Assumes busy is sampled on clk_sys rising edges.
`timescale 1ns/10ps
`default_nettype none
module ppp_host_model (
	input  wire logic       clk_sys,
	input  wire logic       busy,
	output logic            strobeN,
	output logic [11:0]     main_magnitude_field,
	output logic [7:0]      limit_magnitude_field,
	output logic            output_range_select,
	output logic            polaritySelect,
	output logic            modeSelect,
	output logic            panel_or_bus_select
);
	// Idle pins; bus control is held for remote programming
	initial begin
		{strobeN, panel_or_bus_select} = 2'h3;
		{main_magnitude_field, limit_magnitude_field} = 20'h00000;
		{output_range_select, polaritySelect, modeSelect} = 3'h0;
	end

	// One word; waitIdle clear lets a strobe land inside a running transfer
	task automatic send(input logic [11:0] m, input logic [7:0] l,
		input logic [2:0] rpm, input bit waitIdle);
		while (waitIdle && busy !== 1'b0)
			@(posedge clk_sys);
		@(posedge clk_sys);
		{main_magnitude_field, limit_magnitude_field, output_range_select, polaritySelect,
			modeSelect, strobeN} <= {m, l, rpm, 1'b0};
		repeat (ppp_pkg::STROBE_MIN_NS / ppp_pkg::CLK_PERIOD_NS) @(posedge clk_sys);
		// Lines reused at once, so a late sample sees the inverse
		{main_magnitude_field, limit_magnitude_field, output_range_select, polaritySelect,
			modeSelect, strobeN} <= {~{m, l, rpm}, 1'b1};
	endtask : send
endmodule : ppp_host_model
`default_nettype wire

// [ppp_parallel_port.sv]
// Parallel programming port: strobe capture, busy timing and channel steering.
// Assumes all pin inputs are synchronous to clk_sys and a classic Wishbone master.
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module ppp_parallel_port #(
	parameter logic DECIMAL_BUILD = 1'b0
) (
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	// Parallel port pins
	input  wire logic                        strobeN,
	input  wire logic [ppp_pkg::MAIN_W-1:0]  main_magnitude_field,
	input  wire logic [ppp_pkg::LIMIT_W-1:0] limit_magnitude_field,
	input  wire logic                        output_range_select,
	input  wire logic                        polaritySelect,
	input  wire logic                        modeSelect,
	input  wire logic                        panel_or_bus_select,
	input  wire logic                        negLogicStrap,
	output logic                             busy,
	// Converter side
	output logic [ppp_pkg::MAIN_W-1:0]       mainCode,
	output logic [ppp_pkg::LIMIT_W-1:0]      limitCode,
	output logic                             mainRangeLow,
	output logic                             mainNegative,
	output logic                             mainIsCurrent,
	output logic                             limitIsVoltage,
	output logic                             busControl,
	output logic                             convLoad,
	// Wishbone slave
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [4:0]                  wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic [31:0]                      wb_dat_o,
	output logic                             wb_ack_o
);

	// Invert a field when the strap selects negative logic
	function automatic logic [11:0] applySense(input logic [11:0] v, input logic neg);
		applySense = neg ? ~v : v;
	endfunction : applySense

	// Weight 8-4-2-1 digits, most significant digit first, into binary
	function automatic logic [11:0] bcdToBin(input logic [11:0] v, input int digits);
		logic [11:0] acc;
		acc = 12'h000;
		for (int i = digits - 1; i >= 0; i--) begin
			acc = 12'((acc * 12'h00A) + {8'h00, v[i*4 +: 4]});
		end
		bcdToBin = acc;
	endfunction : bcdToBin

	// Registers
	ppp_pkg::ppp_state_t             state_r,    state_nxt;
	logic [4:0]                      divCnt_r;
	logic [5:0]                      tickCnt_r;
	logic                            strobeN_r;
	logic [ppp_pkg::MAIN_W-1:0]      mainTmp_r;
	logic [ppp_pkg::LIMIT_W-1:0]     limitTmp_r;
	logic                            rangeTmp_r;
	logic                            polTmp_r;
	logic                            modeTmp_r;
	logic                            busy_r;
	logic [ppp_pkg::MAIN_W-1:0]      mainCode_r;
	logic [ppp_pkg::LIMIT_W-1:0]     limitCode_r;
	logic                            rangeLow_r;
	logic                            negative_r;
	logic                            current_r;
	logic                            busCtl_r;
	logic                            convLoad_r;
	logic                            enable_r;
	logic [1:0]                      event_r;
	logic [31:0]                     rdData_r;
	logic                            ack_r;

	// Decode
	wire logic        xferFall   = (divCnt_r == 5'(ppp_pkg::XFER_DIV - 1));
	wire logic        strobeFall = strobeN_r & ~strobeN;
	wire logic        idle       = (state_r == ppp_pkg::ST_IDLE);
	wire logic        accept     = strobeFall & idle & enable_r;
	wire logic        ignored    = strobeFall & ~idle;
	wire logic        lastTick   = (state_r == ppp_pkg::ST_XFER) & xferFall & (tickCnt_r == 6'h00);
	wire logic        busReq     = wb_cyc_i & wb_stb_i & ~ack_r;
	wire logic        busWr      = busReq & wb_we_i & wb_sel_i[0];
	wire logic [11:0] mainIn     = applySense(main_magnitude_field, negLogicStrap); // R7
	wire logic [11:0] limitIn    = applySense({4'h0, limit_magnitude_field}, negLogicStrap); // R7
	wire logic        rangeIn    = negLogicStrap ^ output_range_select; // R6
	wire logic        polIn      = negLogicStrap ^ polaritySelect; // R6
	wire logic [11:0] mainBin    = DECIMAL_BUILD ? bcdToBin(mainTmp_r, 3) : mainTmp_r; // R12 R13
	wire logic [11:0] limitBin   = DECIMAL_BUILD ? bcdToBin({4'h0, limitTmp_r}, 2)
	                                             : {4'h0, limitTmp_r}; // R12 R14
	wire logic        wrCtrl     = busWr & (wb_adr_i == ppp_pkg::REG_CTRL);
	wire logic        wrEvent    = busWr & (wb_adr_i == ppp_pkg::REG_EVENT);
	wire logic [1:0]  evSet      = {lastTick, ignored};
	wire logic [1:0]  evClr      = wrEvent ? wb_dat_i[1:0] : 2'h0;

	// Status word and read mux
	wire logic [31:0] statusWord = {25'h0, DECIMAL_BUILD, negLogicStrap, negative_r,
	                                rangeLow_r, current_r, busCtl_r, busy_r};
	wire logic [31:0] rdMux =
		(wb_adr_i == ppp_pkg::REG_CTRL)   ? {31'h0, enable_r} :
		(wb_adr_i == ppp_pkg::REG_STATUS) ? statusWord :
		(wb_adr_i == ppp_pkg::REG_MAIN)   ? {20'h0, mainCode_r} :
		(wb_adr_i == ppp_pkg::REG_LIMIT)  ? {24'h0, limitCode_r} :
		(wb_adr_i == ppp_pkg::REG_EVENT)  ? {30'h0, event_r} :
		32'h0000_0000; // Unmapped reads give zero and are still acknowledged

	// Sequencer next state; strobes outside idle fall through unseen
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ppp_pkg::ST_IDLE:   if (accept) state_nxt = ppp_pkg::ST_ARMED; // R16
			ppp_pkg::ST_ARMED:  if (xferFall) state_nxt = ppp_pkg::ST_XFER; // R4
			ppp_pkg::ST_XFER:   if (lastTick) state_nxt = ppp_pkg::ST_FINISH;
			ppp_pkg::ST_FINISH: if (xferFall) state_nxt = ppp_pkg::ST_IDLE; // R4
		endcase
	end

	// Internal transfer clock: its falling edge is a one-cycle tick
	always_ff @(posedge clk_sys) begin
		if (!rst_n || xferFall) begin
			divCnt_r <= 5'h00;
		end else begin
			divCnt_r <= divCnt_r + 5'h01;
		end
	end

	// Sequencer state and strobe edge history
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_r   <= ppp_pkg::ST_IDLE;
			strobeN_r <= 1'b1;
		end else begin
			state_r   <= state_nxt;
			strobeN_r <= strobeN;
		end
	end

	// Temporary storage; after this edge the data pins are free for reuse
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mainTmp_r  <= 12'h000;
			limitTmp_r <= 8'h00;
			rangeTmp_r <= 1'b0;
			polTmp_r   <= 1'b0;
			modeTmp_r  <= 1'b0;
		end else if (accept) begin
			mainTmp_r  <= mainIn; // R2 R3
			limitTmp_r <= limitIn[7:0]; // R2
			rangeTmp_r <= rangeIn; // R17
			polTmp_r   <= polIn; // R17
			modeTmp_r  <= modeSelect; // R17
		end
	end

	// Busy and transfer length in transfer clock periods
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			busy_r    <= 1'b0;
			tickCnt_r <= 6'h00;
		end else if (xferFall) begin
			if (state_r == ppp_pkg::ST_ARMED) begin
				busy_r    <= 1'b1; // R4
				tickCnt_r <= 6'(ppp_pkg::XFER_TICKS - 1);
			end else if (state_r == ppp_pkg::ST_FINISH) begin
				busy_r    <= 1'b0; // R4
			end else if (tickCnt_r != 6'h00) begin
				tickCnt_r <= tickCnt_r - 6'h01;
			end
		end
	end

	// Converter settings change only as a whole, at transfer completion
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mainCode_r  <= 12'h000;
			limitCode_r <= 8'h00;
			rangeLow_r  <= 1'b0;
			negative_r  <= 1'b0;
			current_r   <= 1'b0;
		end else if (lastTick) begin
			mainCode_r  <= mainBin; // R13
			limitCode_r <= limitBin[7:0]; // R14
			rangeLow_r  <= rangeTmp_r; // R10
			negative_r  <= polTmp_r; // R11
			current_r   <= modeTmp_r; // R9 R15
		end
	end

	// Front panel or bus control follows the pin at all times, fixed sense
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			busCtl_r   <= 1'b0;
			convLoad_r <= 1'b0;
		end else begin
			busCtl_r   <= panel_or_bus_select; // R8
			convLoad_r <= lastTick;
		end
	end

	// Control register and sticky events; a new event beats a clear
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			enable_r <= ppp_pkg::CTRL_ENABLE_RST;
			event_r  <= ppp_pkg::EVENT_RST;
		end else begin
			if (wrCtrl) enable_r <= wb_dat_i[ppp_pkg::CTRL_ENABLE_BIT];
			event_r <= (event_r & ~evClr) | evSet; // R16
		end
	end

	// Wishbone answer one cycle after the request; ack drops the next cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ack_r    <= 1'b0;
			rdData_r <= 32'h0000_0000;
		end else begin
			ack_r    <= busReq;
			rdData_r <= busReq ? rdMux : 32'h0000_0000;
		end
	end

	// Outputs straight from flip-flops
	assign busy           = busy_r;
	assign mainCode       = mainCode_r;
	assign limitCode      = limitCode_r;
	assign mainRangeLow   = rangeLow_r;
	assign mainNegative   = negative_r;
	assign mainIsCurrent  = current_r; // R9 R15
	assign limitIsVoltage = current_r; // R15
	assign busControl     = busCtl_r;
	assign convLoad       = convLoad_r;
	assign wb_dat_o       = rdData_r;
	assign wb_ack_o       = ack_r;

endmodule : ppp_parallel_port

`default_nettype wire

// [ppp_pkg.sv]
// Constants, register map and timing for the parallel programming port.
// Assumes a 25 MHz system clock and a classic Wishbone slave with 32-bit data.
// Functional notes
// R1: Controller holds the strobe low at least 2 us per transfer.
// R2: Strobe high-to-low edge loads the temporary storage registers from the data inputs.
// R3: After the strobe the card no longer needs the data inputs.
// R4: Busy rises on a transfer clock fall, drops on the fall after completion.
// R5: Controller issues the next strobe only after busy returns low.
// R6: Strap picks positive (low=0) or negative (low=1) input logic; positive by default.
// R7: Logic sense applies to magnitude, polarity and range; not control or strobe.
// R8: Panel-or-bus input high gives bus control, low gives front-panel control.
// R9: Mode low selects voltage mode: main is voltage, limit is current limit.
// R10: Range high sets the main channel low range, low sets high range.
// R11: Polarity high makes the main output negative, low makes it positive.
// R12: Magnitudes decode as binary or BCD, fixed by the card build.
// R13: Main magnitude is 12 bits, MSB first; decimal build has three BCD digits.
// R14: Limit magnitude is 8 bits, MSB first; decimal build has two BCD digits.
// R15: Current mode steers main to current and limit to voltage limit together.
// R16: A strobe edge arriving during a transfer is ignored.
// R17: Range, polarity and mode are captured on the same strobe edge as magnitudes.
package ppp_pkg;

	// Clock and transfer timing
	localparam int CLK_PERIOD_NS     = 40;
	localparam int STROBE_MIN_NS     = 2000;
	localparam int XFER_CLK_NS       = 1000;
	localparam int XFER_TIME_NS      = 35000;
	localparam int XFER_DIV          = XFER_CLK_NS / CLK_PERIOD_NS;
	localparam int XFER_TICKS        = XFER_TIME_NS / XFER_CLK_NS;

	// Field widths
	localparam int MAIN_W            = 12;
	localparam int LIMIT_W           = 8;

	// Register byte offsets
	localparam logic [4:0] REG_CTRL   = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h04;
	localparam logic [4:0] REG_MAIN   = 5'h08;
	localparam logic [4:0] REG_LIMIT  = 5'h0C;
	localparam logic [4:0] REG_EVENT  = 5'h10;

	// Field positions
	localparam int CTRL_ENABLE_BIT    = 0;
	localparam int ST_BUSY_BIT        = 0;
	localparam int ST_BUSCTL_BIT      = 1;
	localparam int ST_CURRENT_BIT     = 2;
	localparam int ST_RANGELOW_BIT    = 3;
	localparam int ST_NEGATIVE_BIT    = 4;
	localparam int ST_NEGLOGIC_BIT    = 5;
	localparam int ST_DECIMAL_BIT     = 6;
	localparam int EV_IGNORED_BIT     = 0;
	localparam int EV_DONE_BIT        = 1;

	// Reset values
	localparam logic       CTRL_ENABLE_RST = 1'b1;
	localparam logic [1:0] EVENT_RST       = 2'h0;

	// Transfer sequencer states
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ARMED  = 2'b01,
		ST_XFER   = 2'b10,
		ST_FINISH = 2'b11
	} ppp_state_t;

endpackage : ppp_pkg

// [ppp_port_chk.sv]
// Assertions on the pins and bus of the parallel programming port.
// Assumes one clk_sys domain with a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module ppp_port_chk (
	input wire logic                        clk_sys,
	input wire logic                        rst_n,
	input wire logic                        strobeN,
	input wire logic                        panel_or_bus_select,
	input wire logic                        busy,
	input wire logic [ppp_pkg::MAIN_W-1:0]  mainCode,
	input wire logic [ppp_pkg::LIMIT_W-1:0] limitCode,
	input wire logic                        mainRangeLow,
	input wire logic                        mainNegative,
	input wire logic                        mainIsCurrent,
	input wire logic                        limitIsVoltage,
	input wire logic                        busControl,
	input wire logic                        convLoad,
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_ack_o
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [9:0] busyCnt_r;
	logic [7:0] fallAge_r;

	// Busy length and age of the last strobe fall; age saturates so stale falls never match
	always_ff @(posedge clk_sys) begin
		busyCnt_r <= (rst_n && busy) ? busyCnt_r + 10'h001 : 10'h000;
		if (!rst_n)
			fallAge_r <= 8'hFF;
		else if ($fell(strobeN))
			fallAge_r <= 8'h00;
		else if (fallAge_r != 8'hFF)
			fallAge_r <= fallAge_r + 8'h01;
	end

	chk_busy_length: assert property ($past(rst_n) && $fell(busy) |-> busyCnt_r == 10'h384)
		else $error("busy high time wrong");
	chk_busy_cause: assert property ($past(rst_n) && $rose(busy) |-> fallAge_r <= 8'h19)
		else $error("busy rose without a recent strobe");
	chk_load_pulse: assert property (convLoad |=> !convLoad)
		else $error("load pulse too long");
	chk_load_busy: assert property (convLoad |-> busy)
		else $error("load outside busy");
	chk_out_together: assert property (($changed(mainCode) || $changed(limitCode)
		|| $changed(mainRangeLow) || $changed(mainNegative) || $changed(mainIsCurrent))
		|-> busy && convLoad)
		else $error("outputs changed outside a transfer");
	chk_mode_pair: assert property (limitIsVoltage == mainIsCurrent)
		else $error("channel roles disagree");
	chk_bus_follow: assert property ($past(rst_n) |-> busControl == $past(panel_or_bus_select))
		else $error("bus control not following pin");
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acknowledged");
endmodule : ppp_port_chk

bind ppp_parallel_port ppp_port_chk chk_u (.clk_sys, .rst_n, .strobeN, .panel_or_bus_select,
	.busy, .mainCode, .limitCode, .mainRangeLow, .mainNegative, .mainIsCurrent,
	.limitIsVoltage, .busControl, .convLoad, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
`default_nettype wire

// [test_parallel_programming_port.sv]
// Self-checking bench: host model on the pins, Wishbone tasks for registers.
// Assumes the binary build and the package register map.
`timescale 1ns/10ps
`default_nettype none
module test_parallel_programming_port;
	logic        clk_sys = 1'b0, rst_n = 1'b0, negLogicStrap = 1'b0;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [4:0]  wb_adr_i = 5'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, rdat;
	int          num_errors = 0, cmp_count = 0, cycles = 0;
	wire logic   strobeN, output_range_select, polaritySelect, modeSelect, panel_or_bus_select;
	wire logic   busy, mainRangeLow, mainNegative, mainIsCurrent, limitIsVoltage;
	wire logic   busControl, convLoad, wb_ack_o;
	wire logic [11:0] main_magnitude_field, mainCode;
	wire logic [7:0]  limit_magnitude_field, limitCode;
	wire logic [11:0] decMain;
	wire logic [7:0]  decLimit;
	wire logic [31:0] wb_dat_o;

	ppp_host_model host_u (.clk_sys, .busy, .strobeN, .main_magnitude_field,
		.limit_magnitude_field, .output_range_select, .polaritySelect, .modeSelect,
		.panel_or_bus_select);
	ppp_parallel_port dut_u (.clk_sys, .rst_n, .strobeN, .main_magnitude_field,
		.limit_magnitude_field, .output_range_select, .polaritySelect, .modeSelect,
		.panel_or_bus_select, .negLogicStrap, .busy, .mainCode, .limitCode, .mainRangeLow,
		.mainNegative, .mainIsCurrent, .limitIsVoltage, .busControl, .convLoad, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
	// Decimal build on the same pins; only its converter codes are compared
	ppp_parallel_port #(.DECIMAL_BUILD(1'b1)) decimal_u (.clk_sys, .rst_n, .strobeN,
		.main_magnitude_field, .limit_magnitude_field, .output_range_select, .polaritySelect,
		.modeSelect, .panel_or_bus_select, .negLogicStrap, .busy(), .mainCode(decMain),
		.limitCode(decLimit), .mainRangeLow(), .mainNegative(), .mainIsCurrent(),
		.limitIsVoltage(), .busControl(), .convLoad(), .wb_cyc_i(1'b0), .wb_stb_i(1'b0),
		.wb_we_i(1'b0), .wb_adr_i(5'h00), .wb_sel_i(4'h0), .wb_dat_i(32'h0000_0000),
		.wb_dat_o(), .wb_ack_o());

	initial forever #20 clk_sys = ~clk_sys;

	// Ceiling far above four transfers of 900 cycles each
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors = num_errors + 1;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Classic cycle: request held until ack is sampled, then released
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'b11, w, 4'hF, a, d};
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask : wb

	// Send a word and compare converter outputs with the strap-adjusted pins
	task automatic word(input logic [11:0] m, input logic [7:0] l, input logic [2:0] rpm);
		logic [2:0] s;
		host_u.send(m, l, rpm, 1'b1);
		s = {rpm[2:1] ^ {2{negLogicStrap}}, rpm[0]};
		while (busy !== 1'b0)
			@(posedge clk_sys);
		check("main", mainCode, m ^ {12{negLogicStrap}});
		check("limit", limitCode, l ^ {8{negLogicStrap}});
		check("range", mainRangeLow, s[2]);
		check("negative", mainNegative, s[1]);
		check("current", mainIsCurrent, s[0]);
		check("limit voltage", limitIsVoltage, s[0]);
	endtask : word

	initial begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		wb(1'b0, ppp_pkg::REG_CTRL, 32'h0);
		check("ctrl", rdat, 32'h1);
		wb(1'b0, 5'h14, 32'h0);
		check("unmapped", rdat, 32'h0);
		wb(1'b0, ppp_pkg::REG_STATUS, 32'h0);
		check("status", rdat, 32'h2);
		$display("test reset done");
		word(12'hFFF, 8'h00, 3'b100);
		negLogicStrap <= 1'b1;
		word(12'h001, 8'h80, 3'b011);
		$display("test logic sense done");
		negLogicStrap <= 1'b0;
		word(12'h987, 8'h45, 3'b000);
		check("bcd main", decMain, 32'h3DB);
		check("bcd limit", decLimit, 32'h2D);
		$display("test decimal build done");
		wb(1'b1, ppp_pkg::REG_EVENT, 32'h3);
		host_u.send(12'h5A3, 8'h3C, 3'b010, 1'b1);
		host_u.send(12'h0C0, 8'h11, 3'b001, 1'b0);
		while (busy !== 1'b0)
			@(posedge clk_sys);
		check("kept main", mainCode, 32'h5A3);
		check("kept sign", mainNegative, 1'b1);
		wb(1'b0, ppp_pkg::REG_EVENT, 32'h0);
		check("events", rdat, 32'h3);
		$display("test busy strobe done");
		wb(1'b1, ppp_pkg::REG_CTRL, 32'h0);
		host_u.send(12'h777, 8'h77, 3'b000, 1'b1);
		check("off busy", busy, 1'b0);
		check("off main", mainCode, 32'h5A3);
		$display("test disabled done");
		end_sim();
	end
endmodule : test_parallel_programming_port
`default_nettype wire
